// >>> design/drc_refresh_ctrl.sv
// dram refresh controller for one channel with ahb-lite register access
// Overview of operation
// [RULE1] software loads the 14-bit interval so it spans 7.8 us; default c30h
// [RULE2] each interval expiry adds one owed refresh and a tick; each refresh done subtracts
// [RULE3] owed count above low threshold (1..4) requests refresh, raises low flag
// [RULE4] owed count above high threshold (3..6) requests refresh, raises high flag; code requests only above low threshold (high 3, low 4: no request at 4)
// [RULE5] owed count above panic threshold (5..8) requests refresh, raises panic flag
// [RULE6] refresh off, counting on: accumulate only; both off: neither refresh nor count
// [RULE7] refresh on: requests issued and counter always runs
// [RULE8] software uses counting enable to keep owing refreshes while refresh is off
// [RULE9] mode bit clear: all ranks staggered atomically; set: ranks refreshed independently
// [RULE10] independent mode: compensation service waits programmed number of ticks
// [RULE11] init-done bit set by software, reads back, resets to zero
`timescale 1ns/100ps
module drc_refresh_ctrl
    import drc_pkg::*;
#(
    parameter int OWED_W = 4
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // scheduler side
    input wire drc_sched_in_t sched_in,
    output drc_sched_out_t sched_out,
    output logic rank_independent,
    output logic refresh_tick,
    output logic memory_init_complete,
    // interrupt
    output logic irq
);
    logic wr_en;
    logic [DRC_ADDR_W-1:0] wr_addr;
    logic rd_en;
    logic [DRC_ADDR_W-1:0] rd_addr;
    logic [47:0] ctrl;
    logic [47:0] next_ctrl;
    logic [DRC_TMO_W-1:0] interval_cnt;
    logic [OWED_W-1:0] owed;
    logic [OWED_W-1:0] next_owed;
    logic tick;
    logic counting;
    logic refresh_enable;
    logic [3:0] low_thr;
    logic [3:0] high_thr;
    logic [3:0] panic_thr;
    logic above_low;
    logic above_high;
    logic above_panic;
    logic [DRC_IRQ_W-1:0] irq_stat;
    logic [DRC_IRQ_W-1:0] irq_mask;
    logic [DRC_IRQ_W-1:0] irq_event;
    drc_comp_state_t comp_state;
    logic [DRC_WIN_W-1:0] comp_left;
    logic [DRC_WIN_W-1:0] comp_window;
    logic comp_pending;
    logic [3:0] sched_lvl;
    logic comp_grant;

    drc_ahb_slave u_bus (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .rd_en(rd_en),
        .rd_addr(rd_addr)
    );

    // control register: two word halves, reserved bits held at zero
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_en && wr_addr == DRC_ADDR_CTRL_LO)
        begin
            next_ctrl[31:0] = hwdata & DRC_CTRL_WMASK[31:0]; // RULE1 RULE11
        end
        else if (wr_en && wr_addr == DRC_ADDR_CTRL_HI)
        begin
            next_ctrl[47:32] = hwdata[15:0] & DRC_CTRL_WMASK[47:32];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= DRC_CTRL_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    assign refresh_enable = ctrl[DRC_F_REFRESH_ENABLE];
    assign counting = refresh_enable || ctrl[DRC_F_CNTEN]; // RULE6 RULE7 RULE8

    // interval timer; a zero load is treated as one cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            interval_cnt <= '0;
        end
        else if (!counting || tick)
        begin
            interval_cnt <= '0; // RULE6
        end
        else
        begin
            interval_cnt <= interval_cnt + 1'b1; // RULE1
        end
    end

    assign tick = counting && (interval_cnt + 1'b1 >= ctrl[DRC_F_TMO_LSB +: DRC_TMO_W]);

    // owed refresh count, saturating both ways
    always_comb
    begin
        next_owed = owed;
        if (tick && !(sched_in.refresh_done && refresh_enable))
        begin
            if (owed != '1)
            begin
                next_owed = owed + 1'b1; // RULE2
            end
        end
        else if (!tick && sched_in.refresh_done && refresh_enable && owed != '0)
        begin
            next_owed = owed - 1'b1; // RULE2
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            owed <= '0;
        end
        else
        begin
            owed <= next_owed;
        end
    end

    assign low_thr = DRC_LOW_BASE + {2'b00, ctrl[DRC_F_LOW_LSB +: 2]};
    assign high_thr = DRC_HIGH_BASE + {2'b00, ctrl[DRC_F_HIGH_LSB +: 2]};
    assign panic_thr = DRC_PANIC_BASE + {2'b00, ctrl[DRC_F_PANIC_LSB +: 2]};
    assign above_low = owed > OWED_W'(low_thr);
    assign above_high = owed > OWED_W'(high_thr);
    assign above_panic = owed > OWED_W'(panic_thr);

    // scheduler outputs registered; no request while refresh is disabled
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sched_lvl <= '0;
            refresh_tick <= 1'b0;
            rank_independent <= 1'b0;
            memory_init_complete <= 1'b0;
        end
        else
        begin
            // request, low, high, panic; each process owns its own flops
            sched_lvl <= {refresh_enable && above_low, refresh_enable && above_low,
                refresh_enable && above_high, refresh_enable && above_panic}; // RULE3 RULE4 RULE5 RULE6
            refresh_tick <= tick; // RULE2
            rank_independent <= next_ctrl[DRC_F_RANKMODE]; // RULE9
            memory_init_complete <= next_ctrl[DRC_F_MEMORY_INIT_COMPLETE]; // RULE11
        end
    end

    // compensation service: wait the longest window in ticks in independent mode
    always_comb
    begin
        comp_window = ctrl[DRC_F_CWAIT_LSB +: DRC_WIN_W];
        if (ctrl[DRC_F_DIRQ_LSB +: DRC_WIN_W] > comp_window)
        begin
            comp_window = ctrl[DRC_F_DIRQ_LSB +: DRC_WIN_W];
        end
        if (ctrl[DRC_F_INDQ_LSB +: DRC_WIN_W] > comp_window)
        begin
            comp_window = ctrl[DRC_F_INDQ_LSB +: DRC_WIN_W];
        end
    end

    assign comp_pending = sched_in.comp_req;
    assign sched_out = {sched_lvl, comp_grant};

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            comp_state <= DRC_COMP_IDLE;
            comp_left <= '0;
            comp_grant <= 1'b0;
        end
        else
        begin
            case (comp_state)
                DRC_COMP_IDLE:
                begin
                    comp_grant <= 1'b0;
                    if (comp_pending)
                    begin
                        if (ctrl[DRC_F_RANKMODE] && comp_window != '0)
                        begin
                            comp_state <= DRC_COMP_WAIT; // RULE10
                            comp_left <= comp_window;
                        end
                        else
                        begin
                            // staggered mode serves compensation with no wait
                            comp_state <= DRC_COMP_GRANT; // RULE9
                            comp_grant <= 1'b1;
                        end
                    end
                end
                DRC_COMP_WAIT:
                begin
                    if (tick)
                    begin
                        comp_left <= comp_left - 1'b1; // RULE10
                        if (comp_left == 5'h01)
                        begin
                            comp_state <= DRC_COMP_GRANT;
                            comp_grant <= 1'b1;
                        end
                    end
                end
                DRC_COMP_GRANT:
                begin
                    // grant holds until the request drops
                    if (!comp_pending)
                    begin
                        comp_state <= DRC_COMP_IDLE;
                        comp_grant <= 1'b0;
                    end
                end
                default:
                begin
                    comp_state <= DRC_COMP_IDLE;
                    comp_grant <= 1'b0;
                end
            endcase
        end
    end

    // interrupts: sticky, write one to clear, set wins over clear
    always_comb
    begin
        irq_event = '0;
        irq_event[DRC_IRQ_TICK] = tick;
        irq_event[DRC_IRQ_HIGH] = refresh_enable && above_high;
        irq_event[DRC_IRQ_PANIC] = refresh_enable && above_panic;
        irq_event[DRC_IRQ_COMP] = comp_state == DRC_COMP_WAIT && tick && comp_left == 5'h01;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_en && wr_addr == DRC_ADDR_IRQ_STAT)
            begin
                irq_stat <= (irq_stat & ~hwdata[DRC_IRQ_W-1:0]) | irq_event;
            end
            else
            begin
                irq_stat <= irq_stat | irq_event;
            end
            if (wr_en && wr_addr == DRC_ADDR_IRQ_MASK)
            begin
                irq_mask <= hwdata[DRC_IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // read data registered from the address phase; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata <= '0;
        end
        else if (rd_en)
        begin
            if (rd_addr == DRC_ADDR_CTRL_LO)
            begin
                hrdata <= next_ctrl[31:0];
            end
            else if (rd_addr == DRC_ADDR_CTRL_HI)
            begin
                hrdata <= {16'h0000, next_ctrl[47:32]};
            end
            else if (rd_addr == DRC_ADDR_STATUS)
            begin
                hrdata <= {20'h00000, 4'(owed), 2'b00, comp_state == DRC_COMP_WAIT,
                    sched_out.flag_panic, sched_out.flag_high, sched_out.flag_low,
                    sched_out.refresh_req, counting};
            end
            else if (rd_addr == DRC_ADDR_IRQ_STAT)
            begin
                hrdata <= {28'h0000000, irq_stat};
            end
            else if (rd_addr == DRC_ADDR_IRQ_MASK)
            begin
                hrdata <= {28'h0000000, irq_mask};
            end
            else
            begin
                hrdata <= '0;
            end
        end
    end

    // zero wait states, always okay
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

// >>> design/drc_pkg.sv
// package for the dram refresh controller: map, fields, reset values, carriers
package drc_pkg;
    // register map (byte addresses); 0x669 is a word index, so the byte address is index*4
    localparam logic [11:0] DRC_IDX_CTRL = 12'h669;
    localparam logic [13:0] DRC_ADDR_CTRL_LO = {DRC_IDX_CTRL, 2'b00};
    localparam logic [13:0] DRC_ADDR_CTRL_HI = DRC_ADDR_CTRL_LO + 14'h0004;
    localparam logic [13:0] DRC_ADDR_STATUS = DRC_ADDR_CTRL_LO + 14'h0008;
    localparam logic [13:0] DRC_ADDR_IRQ_STAT = DRC_ADDR_CTRL_LO + 14'h000c;
    localparam logic [13:0] DRC_ADDR_IRQ_MASK = DRC_ADDR_CTRL_LO + 14'h0010;
    localparam int DRC_ADDR_W = 14;

    // 48-bit control register
    localparam logic [47:0] DRC_CTRL_RESET = 48'h0218_3000_0c30;
    localparam logic [47:0] DRC_CTRL_WMASK = 48'h03ff_fbcf_ffff;
    localparam int DRC_F_DIRQ_LSB = 37;
    localparam int DRC_F_INDQ_LSB = 32;
    localparam int DRC_F_CWAIT_LSB = 27;
    localparam int DRC_F_CNTEN = 25;
    localparam int DRC_F_RANKMODE = 24;
    localparam int DRC_F_REFRESH_ENABLE = 23;
    localparam int DRC_F_MEMORY_INIT_COMPLETE = 22;
    localparam int DRC_F_PANIC_LSB = 18;
    localparam int DRC_F_HIGH_LSB = 16;
    localparam int DRC_F_LOW_LSB = 14;
    localparam int DRC_F_TMO_LSB = 0;
    localparam int DRC_TMO_W = 14;
    localparam int DRC_WIN_W = 5;

    // threshold bases: code 0 selects these, code 3 adds three
    localparam logic [3:0] DRC_LOW_BASE = 4'h1;
    localparam logic [3:0] DRC_HIGH_BASE = 4'h3;
    localparam logic [3:0] DRC_PANIC_BASE = 4'h5;

    // interrupt bit positions
    localparam int DRC_IRQ_TICK = 0;
    localparam int DRC_IRQ_HIGH = 1;
    localparam int DRC_IRQ_PANIC = 2;
    localparam int DRC_IRQ_COMP = 3;
    localparam int DRC_IRQ_W = 4;

    localparam logic [1:0] DRC_HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] DRC_HSIZE_WORD = 3'b010;

    typedef struct packed {
        logic refresh_req;
        logic flag_low;
        logic flag_high;
        logic flag_panic;
        logic comp_grant;
    } drc_sched_out_t;

    typedef struct packed {
        logic refresh_done;
        logic comp_req;
    } drc_sched_in_t;

    typedef enum logic [1:0] {
        DRC_COMP_IDLE,
        DRC_COMP_WAIT,
        DRC_COMP_GRANT
    } drc_comp_state_t;
endpackage

// >>> design/drc_ahb_slave.sv
// ahb-lite slave front end: latches address phase, produces write/read strobes
`timescale 1ns/100ps
module drc_ahb_slave
    import drc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    // register side
    output logic wr_en,
    output logic [DRC_ADDR_W-1:0] wr_addr,
    output logic rd_en,
    output logic [DRC_ADDR_W-1:0] rd_addr
);
    logic take;
    logic ph_write;
    logic ph_valid;
    logic [DRC_ADDR_W-1:0] ph_addr;

    // only whole-word single transfers are acted on; others complete with no effect
    assign take = hsel && hready && htrans == DRC_HTRANS_NONSEQ && hsize == DRC_HSIZE_WORD;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= '0;
        end
        else if (hready)
        begin
            ph_valid <= take;
            ph_write <= hwrite;
            ph_addr <= haddr[DRC_ADDR_W-1:0];
        end
    end

    assign wr_en = ph_valid && ph_write;
    assign wr_addr = ph_addr;
    // read decode happens in the address phase so hrdata is a flop in the data phase
    assign rd_en = take && !hwrite;
    assign rd_addr = haddr[DRC_ADDR_W-1:0];
endmodule

// >>> verif/drc_refresh_ctrl_monitor.sv
// checker for the refresh controller ports, bound to the top module
`timescale 1ns/100ps
module drc_refresh_ctrl_monitor
    import drc_pkg::*;
#(
    parameter int OWED_W = 4
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // scheduler side
    input wire drc_sched_in_t sched_in,
    input wire drc_sched_out_t sched_out,
    input wire logic refresh_tick
);
    logic rd_take;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    assign rd_take = hsel && hready && htrans == DRC_HTRANS_NONSEQ && !hwrite
        && hsize == DRC_HSIZE_WORD;

    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    zero_wait_a: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    read_hold_a: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data changed without a read");
    tick_pulse_a: assert property (refresh_tick |=> !refresh_tick)
        else $error("tick longer than one cycle");
    low_request_a: assert property (sched_out.refresh_req == sched_out.flag_low)
        else $error("request and low flag disagree");
    high_request_a: assert property (sched_out.flag_high |-> sched_out.refresh_req)
        else $error("high flag without request");
    panic_request_a: assert property (sched_out.flag_panic |-> sched_out.refresh_req)
        else $error("panic flag without request");
    grant_hold_a: assert property (sched_out.comp_grant && sched_in.comp_req
        |=> sched_out.comp_grant)
        else $error("grant dropped while requested");
    grant_drop_a: assert property (sched_out.comp_grant && !sched_in.comp_req
        |=> !sched_out.comp_grant)
        else $error("grant kept after request ended");
endmodule

bind drc_refresh_ctrl drc_refresh_ctrl_monitor #(.OWED_W(OWED_W)) u_drc_refresh_ctrl_monitor (
    .clk_sys, .rst_n, .hsel, .htrans, .hwrite, .hsize, .hready, .hreadyout,
    .hresp, .hrdata, .sched_in, .sched_out, .refresh_tick
);

// >>> verif/drc_sched_model.sv
// command scheduler model: answers refresh requests, raises compensation requests
`timescale 1ns/100ps
module drc_sched_model
    import drc_pkg::*;
#(
    parameter int GAP = 4
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bench control
    input wire logic stall,
    input wire logic comp_go,
    // controller side
    input wire drc_sched_out_t sched_out,
    output drc_sched_in_t sched_in
);
    int gap;

    // gap lets the request level catch up, so no refresh is issued on a stale request
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sched_in <= '0;
            gap <= 0;
        end
        else
        begin
            // one assignment per signal per edge
            if (gap != 0)
            begin
                sched_in.refresh_done <= 1'b0;
                gap <= gap - 1;
            end
            else
            begin
                sched_in.refresh_done <= sched_out.refresh_req && !stall;
                gap <= (sched_out.refresh_req && !stall) ? GAP : 0;
            end
            if (sched_out.comp_grant)
                sched_in.comp_req <= 1'b0;
            else if (comp_go)
                sched_in.comp_req <= 1'b1;
        end
    end
endmodule

// >>> verif/drc_refresh_ctrl_tb.sv
// testbench for the refresh controller: register access, watermarks, compensation, irq
`timescale 1ns/100ps
module drc_refresh_ctrl_tb
    import drc_pkg::*;
;
    logic clk_sys = 0;
    logic rst_n = 0;
    logic hsel = 0;
    logic hwrite = 0;
    logic stall = 1;
    logic comp_go = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = DRC_HSIZE_WORD;
    logic hreadyout, hresp, rank_independent, refresh_tick, memory_init_complete, irq;
    logic [31:0] hrdata;
    logic [31:0] q;
    drc_sched_out_t sched_out;
    drc_sched_in_t sched_in;
    int err_total = 0;
    int n_compared = 0;
    int ticks = 0;
    int s;

    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys or negedge rst_n)
        ticks <= !rst_n ? 0 : ticks + (refresh_tick === 1'b1);

    drc_refresh_ctrl u_drc_refresh_ctrl (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sched_in(sched_in),
        .sched_out(sched_out), .rank_independent(rank_independent),
        .refresh_tick(refresh_tick), .memory_init_complete(memory_init_complete), .irq(irq)
    );

    drc_sched_model u_drc_sched_model (
        .clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .comp_go(comp_go),
        .sched_out(sched_out), .sched_in(sched_in)
    );

    task give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // 0 bus ready, 1 tick, 2 grant, 3 request gone
    task await(input int k);
        int n;
        logic v;
        for (n = 0; n < 300; n++)
        begin
            @(posedge clk_sys);
            v = k == 0 ? hreadyout : k == 1 ? refresh_tick : k == 2 ? sched_out.comp_grant
                : !sched_out.refresh_req;
            if (v === 1'b1)
                break;
        end
        if (n == 300)
        begin
            chk("wait bound", 0, k + 1);
            give_verdict();
        end
    endtask

    task bus(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= DRC_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {18'h0, a};
        await(0);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        await(0);
        q = hrdata;
    endtask

    task rd(input string nm, input logic [13:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // m holds counting enable, rank mode, refresh enable, init done
    function logic [31:0] lo(input logic [13:0] t, input logic [1:0] c, input logic [3:0] m,
        input logic [4:0] wt);
        return {wt, 1'b0, m, 2'b00, c, c, c, t};
    endfunction

    initial
    begin
        cyc(20);
        rst_n <= 1'b1;
        rd("ctrl_lo reset", DRC_ADDR_CTRL_LO, 32'h3000_0c30);
        rd("ctrl_hi reset", DRC_ADDR_CTRL_HI, 32'h0000_0218);
        chk("init port", 0, memory_init_complete);
        rd("unmapped", DRC_ADDR_CTRL_LO - 14'h0004, 32'h0);
        bus(1'b1, DRC_ADDR_CTRL_HI, 32'hffff_ffff);
        rd("ctrl_hi masked", DRC_ADDR_CTRL_HI, 32'h0000_03ff);
        // counting only: owed grows, nothing requested
        bus(1'b1, DRC_ADDR_CTRL_LO, lo(14'h10, 0, 4'b1000, 0));
        await(1);
        s = $time;
        await(1);
        chk("tick gap", 16, ($time - s) / 10);
        await(1);
        cyc(2);
        rd("status count only", DRC_ADDR_STATUS, {20'h0, ticks[3:0], 8'h01});
        chk("no request", 0, sched_out);
        bus(1'b1, DRC_ADDR_CTRL_LO, lo(14'h10, 0, 4'b0000, 0));
        s = ticks;
        cyc(60);
        chk("stopped ticks", s, ticks);
        rd("status stopped", DRC_ADDR_STATUS, {20'h0, ticks[3:0], 8'h00});
        // each watermark code; a reset clears the owed count between codes
        for (int c = 0; c < 4; c++)
        begin
            rst_n <= 1'b0;
            stall <= 1'b1;
            cyc(2);
            rst_n <= 1'b1;
            rd("ctrl_lo after reset", DRC_ADDR_CTRL_LO, 32'h3000_0c30);
            bus(1'b1, DRC_ADDR_CTRL_LO, lo(14'h40, c, 4'b0010, 0));
            for (int k = 1; k <= 6 + c; k++)
            begin
                await(1);
                cyc(2);
                chk("flags", {k > 1 + c, k > 1 + c, k > 3 + c, k > 5 + c},
                    sched_out[4:1]);
            end
            stall <= 1'b0;
            await(3);
            cyc(3);
            rd("drained", DRC_ADDR_STATUS, {20'h0, 4'(1 + c), 8'h01});
        end
        // compensation: independent mode waits for the largest window
        bus(1'b1, DRC_ADDR_CTRL_HI, 32'h0000_0041);
        bus(1'b1, DRC_ADDR_CTRL_LO, lo(14'h40, 0, 4'b0110, 5'd3));
        // port flops update at the write edge; look one cycle later
        cyc(1);
        chk("rank port", 1, rank_independent);
        for (int m = 1; m >= 0; m--)
        begin
            s = ticks;
            comp_go <= 1'b1;
            await(2);
            comp_go <= 1'b0;
            cyc(1);
            chk("comp ticks", 3 * m, ticks - s);
            cyc(3);
            chk("grant gone", 0, sched_out.comp_grant);
            bus(1'b1, DRC_ADDR_CTRL_LO, lo(14'h40, 0, 4'b0010, 5'd3));
            cyc(1);
            chk("rank port", 0, rank_independent);
        end
        // tick interrupt: masked, unmasked, cleared
        bus(1'b1, DRC_ADDR_IRQ_MASK, 32'h0);
        bus(1'b1, DRC_ADDR_IRQ_STAT, 32'hf);
        await(1);
        cyc(2);
        chk("irq masked", 0, irq);
        rd("irq status", DRC_ADDR_IRQ_STAT, 32'h1);
        bus(1'b1, DRC_ADDR_IRQ_MASK, 32'h1);
        cyc(2);
        chk("irq raised", 1, irq);
        bus(1'b1, DRC_ADDR_IRQ_STAT, 32'h1);
        cyc(2);
        chk("irq cleared", 0, irq);
        bus(1'b1, DRC_ADDR_CTRL_LO, lo(14'h40, 0, 4'b0011, 0));
        cyc(1);
        chk("init port", 1, memory_init_complete);
        rd("init readback", DRC_ADDR_CTRL_LO, lo(14'h40, 0, 4'b0011, 0));
        give_verdict();
    end
endmodule
